// ### inc/iuvfh_defines.vh
// Register map, field positions, reset values and timing constants of the input undervoltage handler
`ifndef IUVFH_DEFINES_VH
`define IUVFH_DEFINES_VH

// Register indices; byte address is the index times four
`define IUVFH_IDX_WARN 10'h058
`define IUVFH_IDX_FAULT 10'h059
`define IUVFH_IDX_ACTION 10'h05a
`define IUVFH_IDX_EXP 10'h05b
`define IUVFH_IDX_STATUS 10'h05c
`define IUVFH_IDX_MASK 10'h05d
`define IUVFH_IDX_STATE 10'h05e

// Limit register fields
`define IUVFH_LIM_EXP_MSB 15
`define IUVFH_LIM_EXP_LSB 11
`define IUVFH_LIM_MANT_MSB 10
`define IUVFH_LIM_MANT_LSB 0

// Action register fields
`define IUVFH_ACT_RESP_MSB 7
`define IUVFH_ACT_RESP_LSB 6
`define IUVFH_ACT_RETRY_MSB 5
`define IUVFH_ACT_RETRY_LSB 3
`define IUVFH_ACT_DELAY_MSB 2
`define IUVFH_ACT_DELAY_LSB 0

// Exponent register field
`define IUVFH_EXP_MSB 5
`define IUVFH_EXP_LSB 3

// Response codes
`define IUVFH_RESP_NONE 2'h0
`define IUVFH_RESP_RIDE 2'h1
`define IUVFH_RESP_RETRY 2'h2
`define IUVFH_RESP_HOLD 2'h3

// Retry code for unlimited attempts
`define IUVFH_RETRY_INF 3'h7

// Status and mask bit positions
`define IUVFH_ST_WARN 0
`define IUVFH_ST_FAULT 1
`define IUVFH_ST_SHUT 2
`define IUVFH_ST_LATCH 3

// Reset values
`define IUVFH_RST_MANT 11'h000
`define IUVFH_RST_ACTION 8'h00
`define IUVFH_RST_EXP 3'h0
`define IUVFH_RST_MASK 4'h0

// Timing: clock rate and delay times in milliseconds
`define IUVFH_CLK_HZ 20000000
`define IUVFH_MS_PER_S 1000
`define IUVFH_CYC_PER_MS (`IUVFH_CLK_HZ / `IUVFH_MS_PER_S)
`define IUVFH_DT1_BASE_MS 10
`define IUVFH_DT2_MS_0 252
`define IUVFH_DT2_MS_1 558
`define IUVFH_DT2_MS_2 924
`define IUVFH_DT2_MS_3 1260
`define IUVFH_DT2_MS_4 1596
`define IUVFH_DT2_MS_5 1932
`define IUVFH_DT2_MS_6 2268
`define IUVFH_DT2_MS_7 2604

`endif

// ### rtl/iuvfh_delay_sel.v
// Delay code to cycle count lookup for ride-through and restart spacing
`timescale 1ns/10ps
`include "iuvfh_defines.vh"

module iuvfh_delay_sel #(
  parameter CYCLES_PER_MS = `IUVFH_CYC_PER_MS,
  parameter CNT_W = 26
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Delay code
  input wire [2:0] code_in,
  // Cycle counts
  output reg [CNT_W-1:0] dt1_cyc_out,
  output reg [CNT_W-1:0] dt2_cyc_out
);

  reg [31:0] dt1_ms;
  reg [31:0] dt2_ms;
  reg [31:0] dt1_full;
  reg [31:0] dt2_full;

  always @* begin
    dt1_ms = `IUVFH_DT1_BASE_MS << code_in;
    case (code_in)
      3'h0: dt2_ms = `IUVFH_DT2_MS_0;
      3'h1: dt2_ms = `IUVFH_DT2_MS_1;
      3'h2: dt2_ms = `IUVFH_DT2_MS_2;
      3'h3: dt2_ms = `IUVFH_DT2_MS_3;
      3'h4: dt2_ms = `IUVFH_DT2_MS_4;
      3'h5: dt2_ms = `IUVFH_DT2_MS_5;
      3'h6: dt2_ms = `IUVFH_DT2_MS_6;
      default: dt2_ms = `IUVFH_DT2_MS_7;
    endcase
    dt1_full = dt1_ms * CYCLES_PER_MS;
    dt2_full = dt2_ms * CYCLES_PER_MS;
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dt1_cyc_out <= {CNT_W{1'b1}};
      dt2_cyc_out <= {CNT_W{1'b1}};
    end else begin
      dt1_cyc_out <= dt1_full[CNT_W-1:0];
      dt2_cyc_out <= dt2_full[CNT_W-1:0];
    end
  end

endmodule // iuvfh_delay_sel

// ### rtl/iuvfh_top.v
// Input undervoltage supervision with programmable fault response behind an APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "iuvfh_defines.vh"

// Behaviour
// - Warning raised when measured input voltage is below the warning threshold.
// - Fault declared when measured input voltage is below the fault threshold.
// - Limit bits 15..11 read back the shared exponent; threshold is mantissa times 2^N.
// - Limit bits 10..0 hold a writable, readable 11-bit mantissa.
// - Action bits 7..6 select the fault response; code 00 takes no action.
// - Code 01 rides through for Delay Time 1, then follows retry setting.
// - Code 10 shuts the output down at once, then retries per retry setting.
// - Code 11 holds the output off while the fault persists, then re-enables.
// - Retry field bits 5..3 counts restarts; exhausted retries keep output off.
// - A latched fault clears only by reset, power-off/on or bias loss.
// - Restart attempts are spaced by Delay Time 2 from bits 2..0.
// - Delay Time 1 is 10 ms doubling per code; Delay Time 2 from 252 ms.
module iuvfh_top #(
  parameter CYCLES_PER_MS = `IUVFH_CYC_PER_MS,
  parameter CNT_W = 26,
  parameter MANT_W = 11
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Measured input voltage, mantissa in the shared exponent
  input wire [MANT_W-1:0] input_voltage_in,
  input wire input_voltage_vld_in,
  // Power-on request; low then high is a power cycle
  input wire power_on_in,
  // Status outputs
  output reg output_enable_out,
  output reg uv_warning_out,
  output reg uv_fault_out,
  output reg irq_out
);

  localparam S_RUN = 6'h01;
  localparam S_RIDE = 6'h02;
  localparam S_WAIT = 6'h04;
  localparam S_LATCH = 6'h08;
  localparam S_HOLD = 6'h10;
  localparam S_OFF = 6'h20;

  reg [MANT_W-1:0] warn_mant_q;
  reg [MANT_W-1:0] fault_mant_q;
  reg [7:0] action_q;
  reg [2:0] exp_q;
  reg [3:0] status_q;
  reg [3:0] status_d;
  reg [3:0] mask_q;
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [2:0] retry_q;
  reg [2:0] retry_d;
  reg warn_lvl_q;
  reg fault_lvl_q;
  reg warn_lvl_d;
  reg fault_lvl_d;
  reg ev_shut;
  reg ev_latch;
  reg [31:0] rd_d;
  reg hit_d;

  wire [1:0] resp = action_q[`IUVFH_ACT_RESP_MSB:`IUVFH_ACT_RESP_LSB];
  wire [2:0] retry_code = action_q[`IUVFH_ACT_RETRY_MSB:`IUVFH_ACT_RETRY_LSB];
  wire [2:0] delay_code = action_q[`IUVFH_ACT_DELAY_MSB:`IUVFH_ACT_DELAY_LSB];
  wire [CNT_W-1:0] dt1_cyc;
  wire [CNT_W-1:0] dt2_cyc;
  wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [9:0] idx = paddr_in[11:2];
  wire setup = psel_in & ~penable_in;
  wire wr_en = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
  wire [4:0] exp_field = {2'b00, exp_q};
  wire retry_left = (retry_code == `IUVFH_RETRY_INF) | (retry_q < retry_code);

  // Delay code lookup
  iuvfh_delay_sel #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .CNT_W(CNT_W)
  ) u_delay_sel (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .code_in(delay_code),
    .dt1_cyc_out(dt1_cyc),
    .dt2_cyc_out(dt2_cyc)
  );

  // Read mux and address decode
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (idx)
      `IUVFH_IDX_WARN: rd_d = {16'h0000, exp_field, warn_mant_q};
      `IUVFH_IDX_FAULT: rd_d = {16'h0000, exp_field, fault_mant_q};
      `IUVFH_IDX_ACTION: rd_d = {24'h000000, action_q};
      `IUVFH_IDX_EXP: rd_d = {26'h0, exp_q, 3'h0};
      `IUVFH_IDX_STATUS: rd_d = {28'h0000000, status_q};
      `IUVFH_IDX_MASK: rd_d = {28'h0000000, mask_q};
      `IUVFH_IDX_STATE: rd_d = {19'h0, state_q, retry_q, output_enable_out, fault_lvl_q, warn_lvl_q, 1'b0};
      default: hit_d = 1'b0;
    endcase
  end

  // APB handshake, one cycle setup then ready
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup & ~hit_d;
      if (setup) begin
        prdata_out <= (hit_d & ~pwrite_in) ? rd_d : 32'h0000_0000;
      end
    end
  end

  // Writable registers
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warn_mant_q <= `IUVFH_RST_MANT;
      fault_mant_q <= `IUVFH_RST_MANT;
      action_q <= `IUVFH_RST_ACTION;
      exp_q <= `IUVFH_RST_EXP;
      mask_q <= `IUVFH_RST_MASK;
    end else if (wr_en) begin
      if (idx == `IUVFH_IDX_WARN) begin
        warn_mant_q <= pwdata_in[`IUVFH_LIM_MANT_MSB:`IUVFH_LIM_MANT_LSB];
      end
      if (idx == `IUVFH_IDX_FAULT) begin
        fault_mant_q <= pwdata_in[`IUVFH_LIM_MANT_MSB:`IUVFH_LIM_MANT_LSB];
      end
      if (idx == `IUVFH_IDX_ACTION) begin
        action_q <= pwdata_in[7:0];
      end
      if (idx == `IUVFH_IDX_EXP) begin
        exp_q <= pwdata_in[`IUVFH_EXP_MSB:`IUVFH_EXP_LSB];
      end
      if (idx == `IUVFH_IDX_MASK) begin
        mask_q <= pwdata_in[3:0];
      end
    end
  end

  // Threshold comparison; both sides share exponent N so mantissas compare directly
  always @* begin
    warn_lvl_d = warn_lvl_q;
    fault_lvl_d = fault_lvl_q;
    if (input_voltage_vld_in) begin
      warn_lvl_d = input_voltage_in < warn_mant_q;
      fault_lvl_d = input_voltage_in < fault_mant_q;
    end
  end

  // Fault response sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    retry_d = retry_q;
    ev_shut = 1'b0;
    ev_latch = 1'b0;
    if (!power_on_in) begin
      state_d = S_OFF;
      cnt_d = {CNT_W{1'b0}};
      retry_d = 3'h0;
    end else begin
      case (state_q)
        S_OFF: begin
          state_d = S_RUN;
        end
        S_RUN: begin
          cnt_d = cnt_inc;
          if (fault_lvl_q) begin
            cnt_d = {CNT_W{1'b0}};
            case (resp)
              `IUVFH_RESP_RIDE: begin
                state_d = S_RIDE;
              end
              `IUVFH_RESP_RETRY: begin
                ev_shut = 1'b1;
                if (retry_left) begin
                  state_d = S_WAIT;
                end else begin
                  state_d = S_LATCH;
                  ev_latch = 1'b1;
                end
              end
              `IUVFH_RESP_HOLD: begin
                state_d = S_HOLD;
                ev_shut = 1'b1;
              end
              default: begin
                state_d = S_RUN;
              end
            endcase
          end else if (cnt_inc >= dt2_cyc) begin
            cnt_d = {CNT_W{1'b0}};
            retry_d = 3'h0;
          end
        end
        S_RIDE: begin
          cnt_d = cnt_inc;
          if (!fault_lvl_q) begin
            state_d = S_RUN;
            cnt_d = {CNT_W{1'b0}};
          end else if (cnt_inc >= dt1_cyc) begin
            cnt_d = {CNT_W{1'b0}};
            ev_shut = 1'b1;
            if (retry_left) begin
              state_d = S_WAIT;
            end else begin
              state_d = S_LATCH;
              ev_latch = 1'b1;
            end
          end
        end
        S_WAIT: begin
          cnt_d = cnt_inc;
          if (cnt_inc >= dt2_cyc) begin
            state_d = S_RUN;
            cnt_d = {CNT_W{1'b0}};
            if (retry_code != `IUVFH_RETRY_INF) begin
              retry_d = retry_q + 3'h1;
            end
          end
        end
        S_HOLD: begin
          if (!fault_lvl_q) begin
            state_d = S_RUN;
            cnt_d = {CNT_W{1'b0}};
          end
        end
        S_LATCH: begin
          state_d = S_LATCH;
        end
        default: begin
          state_d = S_OFF;
          cnt_d = {CNT_W{1'b0}};
          retry_d = 3'h0;
        end
      endcase
    end
  end

  // Sticky status, write one to clear, set wins
  always @* begin
    status_d = status_q;
    if (wr_en && idx == `IUVFH_IDX_STATUS) begin
      status_d = status_q & ~pwdata_in[3:0];
    end
    if (warn_lvl_d && !warn_lvl_q) begin
      status_d[`IUVFH_ST_WARN] = 1'b1;
    end
    if (fault_lvl_d && !fault_lvl_q) begin
      status_d[`IUVFH_ST_FAULT] = 1'b1;
    end
    if (ev_shut) begin
      status_d[`IUVFH_ST_SHUT] = 1'b1;
    end
    if (ev_latch) begin
      status_d[`IUVFH_ST_LATCH] = 1'b1;
    end
  end

  // State and output flops
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= S_OFF;
      cnt_q <= {CNT_W{1'b0}};
      retry_q <= 3'h0;
      warn_lvl_q <= 1'b0;
      fault_lvl_q <= 1'b0;
      status_q <= 4'h0;
      output_enable_out <= 1'b0;
      uv_warning_out <= 1'b0;
      uv_fault_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      retry_q <= retry_d;
      warn_lvl_q <= warn_lvl_d;
      fault_lvl_q <= fault_lvl_d;
      status_q <= status_d;
      output_enable_out <= (state_d == S_RUN) | (state_d == S_RIDE);
      uv_warning_out <= warn_lvl_d;
      uv_fault_out <= fault_lvl_d;
      irq_out <= |(status_q & mask_q);
    end
  end

endmodule // iuvfh_top

// ### tb/iuvfh_monitor.sv
// Port checker of the input undervoltage handler
`timescale 1ns/10ps
module iuvfh_monitor #(parameter MANT_W = 11) (
  // Clock, reset and APB
  input wire clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in, prdata_out,
  // Measurement, power and status
  input wire [MANT_W-1:0] input_voltage_in,
  input wire input_voltage_vld_in, power_on_in, output_enable_out, uv_warning_out, uv_fault_out, irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error response malformed");
  chk_warn_ceiling: assert property (input_voltage_vld_in && input_voltage_in == {MANT_W{1'b1}} |=> !uv_warning_out)
    else $error("warning on full-scale sample");
  chk_warn_hold: assert property (!input_voltage_vld_in |=> $stable(uv_warning_out))
    else $error("warning moved without sample");
  chk_fault_ceiling: assert property (input_voltage_vld_in && input_voltage_in == {MANT_W{1'b1}} |=> !uv_fault_out)
    else $error("fault on full-scale sample");
  chk_fault_hold: assert property (!input_voltage_vld_in |=> $stable(uv_fault_out))
    else $error("fault moved without sample");
  chk_power_off: assert property (!power_on_in |=> !output_enable_out)
    else $error("output on while power off");
  chk_off_cause: assert property ($fell(output_enable_out) |-> $past(uv_fault_out) || !$past(power_on_in))
    else $error("output dropped without cause");
endmodule // iuvfh_monitor

bind iuvfh_top iuvfh_monitor #(.MANT_W(MANT_W)) iuvfh_monitor_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .input_voltage_in(input_voltage_in), .input_voltage_vld_in(input_voltage_vld_in), .power_on_in(power_on_in),
  .output_enable_out(output_enable_out), .uv_warning_out(uv_warning_out), .uv_fault_out(uv_fault_out),
  .irq_out(irq_out));

// ### tb/testbench.sv
// Self-checking testbench of the input undervoltage handler
`timescale 1ns/10ps
module testbench;
  logic clk=0, rst_n=0, psel=0, pen=0, pwr_w=0, vld=0, pwr=1, ev;
  logic [11:0] pa=0;
  logic [31:0] pwd=0, prd, rv;
  logic [10:0] input_voltage=11'h7ff;
  logic rdy, err, oe, warn, flt, irq;
  int fails=0, n_tests=0, cyc=0;
  iuvfh_top #(.CYCLES_PER_MS(2)) iuvfh_top_i (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr_w), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .input_voltage_in(input_voltage), .input_voltage_vld_in(vld), .power_on_in(pwr),
    .output_enable_out(oe), .uv_warning_out(warn), .uv_fault_out(flt), .irq_out(irq));
  initial forever #25 clk = ~clk;
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      print_verdict;
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer; data and error taken at the edge that sees pready
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr_w <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rv = prd;
    ev = err;
    psel <= 0;
    pen <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string n);
    xf(0, a, 0);
    chk(n, e, rv);
  endtask
  task smp(input logic [10:0] v);
    @(posedge clk);
    input_voltage <= v;
    vld <= 1;
    @(posedge clk);
    vld <= 0;
    repeat (2) @(posedge clk);
  endtask
  task woe(input logic e, input int m);
    repeat (m) if (oe !== e) @(posedge clk);
    chk("output_enable", e, oe);
  endtask
  task pcyc;
    @(posedge clk);
    pwr <= 0;
    repeat (3) @(posedge clk);
    pwr <= 1;
    woe(1, 5);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(12'h160, 0, "warn_reset");
    rd(12'h168, 0, "action_reset");
    xf(1, 12'h160, 32'hffff_ffff);
    xf(1, 12'h16c, 32'h0000_0028);
    rd(12'h160, 32'h0000_2fff, "warn_limit");
    rd(12'h164, 32'h0000_2800, "fault_limit");
    rd(12'h16c, 32'h0000_0028, "exponent");
    xf(0, 12'h17c, 0);
    chk("unmapped_err", 1, ev);
    $display("test registers done");
    xf(1, 12'h160, 32'h100);
    xf(1, 12'h164, 32'h080);
    xf(1, 12'h174, 32'h1);
    smp(11'h0c0);
    chk("warn_low", 1, warn);
    chk("fault_mid", 0, flt);
    chk("irq_set", 1, irq);
    rd(12'h170, 1, "status");
    xf(1, 12'h170, 32'h1);
    smp(11'h100);
    chk("warn_edge", 0, warn);
    chk("irq_clr", 0, irq);
    smp(11'h07f);
    chk("fault_low", 1, flt);
    chk("oe_none", 1, oe);
    $display("test limits done");
    xf(1, 12'h168, 32'h40);
    repeat (10) @(posedge clk);
    chk("oe_ride", 1, oe);
    repeat (8) @(posedge clk);
    chk("oe_ride_late", 1, oe);
    woe(0, 6);
    smp(11'h7ff);
    repeat (30) @(posedge clk);
    chk("oe_latched", 0, oe);
    rd(12'h170, 32'h0000_000f, "status_latch");
    rd(12'h178, 32'h0000_0400, "state_latch");
    pcyc;
    $display("test ride done");
    xf(1, 12'h168, 32'h88);
    smp(11'h07f);
    woe(0, 3);
    repeat (490) @(posedge clk);
    chk("oe_spacing", 0, oe);
    woe(1, 30);
    woe(0, 5);
    smp(11'h7ff);
    xf(1, 12'h168, 32'hc0);
    pcyc;
    smp(11'h07f);
    woe(0, 3);
    smp(11'h7ff);
    woe(1, 3);
    $display("test retry done");
    xf(1, 12'h168, 32'hb8);
    smp(11'h07f);
    repeat (3) begin
      woe(1, 600);
      woe(0, 5);
    end
    $display("test unlimited done");
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    woe(1, 5);
    rd(12'h168, 0, "action_after_reset");
    $display("test reset done");
    print_verdict;
  end
endmodule // testbench
